// ===== common/bsfr_pkg.sv
package bsfr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] BSFR_ADDR_STATUS = 8'h03;
  localparam logic [7:0] BSFR_STATUS_RESET = 8'h00;
  localparam logic [7:0] BSFR_UNMAPPED_DATA = 8'h00;

  // ==========================================================
  // field positions
  localparam int BSFR_BIT_OTWARN = 7;
  localparam int BSFR_BIT_ENSTAT = 6;
  localparam int BSFR_BIT_BOOTERR = 5;
  localparam int BSFR_BIT_SSDONE = 4;
  localparam int BSFR_BIT_HICCUP = 3;
  localparam int BSFR_BIT_OTFAULT = 2;
  localparam int BSFR_BIT_LATCHOFF = 1;
  localparam int BSFR_BIT_PGOOD = 0;

  // ==========================================================
  // timing
  localparam int BSFR_SYNC_STAGES = 2;
  localparam logic [1:0] BSFR_SETTLE_CYCLES = 2'h3;

  // converter condition flags, packed in register bit order
  typedef struct packed {
    logic overtempWarningFlag;
    logic converterEnabled;
    logic bootError;
    logic softstartRampComplete;
    logic hiccupActive;
    logic overtempFaultFlag;
    logic latchedOff;
    logic outputInRegulation;
  } bsfr_status_t;

endpackage : bsfr_pkg

// ===== rtl/bsfr_status_reg.sv
`timescale 1ns/10ps
// Contract
// - An 8-bit read-only status register answers at address 0x03 and reads all zero after reset.
// - Bit 6 shows 1 while the converter is switched on and 0 while it is off.
// - Bit 5 shows 1 when a start-up error occurred and 0 otherwise.
// - Bit 3 shows 1 while the converter runs in current-limit hiccup and 0 otherwise.
// - Bit 1 shows 1 when an overcurrent or overtemperature fault latched the converter off.
module bsfr_status_reg
  import bsfr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // converter condition inputs, asynchronous to mclk
  input wire bsfr_status_t condRaw,
  // register read port
  input wire logic rdEn,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData_q,
  output logic rdValid_q
);

  // ==========================================================
  // synchroniser: analog comparators are not on mclk
  bsfr_status_t syncA_q;
  bsfr_status_t syncB_q;
  bsfr_status_t status_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= condRaw;
      syncB_q <= syncA_q;
    end
  end

  // ==========================================================
  // status register, no write path at all
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= bsfr_status_t'(BSFR_STATUS_RESET);
    end else begin
      status_q <= syncB_q;
    end
  end

  // ==========================================================
  // read port; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData_q <= BSFR_UNMAPPED_DATA;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdEn;
      if (rdEn && rdAddr == BSFR_ADDR_STATUS) begin
        rdData_q <= status_q;
      end else begin
        rdData_q <= BSFR_UNMAPPED_DATA;
      end
    end
  end

  // ==========================================================
  // checks
  logic [1:0] sinceRst_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sinceRst_q <= 2'h0;
    end else if (sinceRst_q != BSFR_SETTLE_CYCLES) begin
      sinceRst_q <= sinceRst_q + 2'h1;
    end
  end

  sequence s_statusRead;
    rdEn && rdAddr == BSFR_ADDR_STATUS;
  endsequence

  sequence s_settled;
    sinceRst_q == BSFR_SETTLE_CYCLES;
  endsequence

  a_reset_zero: assert property (@(posedge mclk)
    srst |=> status_q == bsfr_status_t'(BSFR_STATUS_RESET) && rdData_q == 8'h00 && !rdValid_q)
    else $error("status not zero after reset");

  a_read_status: assert property (@(posedge mclk) disable iff (srst)
    s_statusRead |=> rdValid_q && rdData_q == $past(status_q))
    else $error("status read returned wrong data");

  a_read_unmapped: assert property (@(posedge mclk) disable iff (srst)
    rdEn && rdAddr != BSFR_ADDR_STATUS |=> rdValid_q && rdData_q == 8'h00)
    else $error("unmapped read not zero");

  a_enable_bit: assert property (@(posedge mclk) disable iff (srst)
    s_settled |-> status_q[BSFR_BIT_ENSTAT] == $past(condRaw.converterEnabled, 3))
    else $error("enable bit does not follow converter state");

  a_boot_bit: assert property (@(posedge mclk) disable iff (srst)
    s_settled |-> status_q[BSFR_BIT_BOOTERR] == $past(condRaw.bootError, 3))
    else $error("boot error bit wrong");

  a_hiccup_bit: assert property (@(posedge mclk) disable iff (srst)
    s_settled ##0 $rose(syncB_q.hiccupActive) |=> status_q[BSFR_BIT_HICCUP] ##1 s_settled)
    else $error("hiccup bit did not follow");

  a_latch_bit: assert property (@(posedge mclk) disable iff (srst)
    s_settled |-> status_q[BSFR_BIT_LATCHOFF] == $past(condRaw.latchedOff, 3))
    else $error("latch-off bit wrong");

  a_other_bits: assert property (@(posedge mclk) disable iff (srst)
    s_settled |-> status_q[BSFR_BIT_OTWARN] == $past(condRaw.overtempWarningFlag, 3)
      && status_q[BSFR_BIT_SSDONE] == $past(condRaw.softstartRampComplete, 3)
      && status_q[BSFR_BIT_OTFAULT] == $past(condRaw.overtempFaultFlag, 3)
      && status_q[BSFR_BIT_PGOOD] == $past(condRaw.outputInRegulation, 3))
    else $error("warning, ramp, fault or power-good bit wrong");

  // ==========================================================
  // read port and pipe housekeeping
  a_valid_idle: assert property (@(posedge mclk) disable iff (srst)
    !rdEn |=> !rdValid_q && rdData_q == BSFR_UNMAPPED_DATA)
    else $error("read port not idle without a request");

  // a stale level left in the pipe would leak into the first reads
  a_sync_clear: assert property (@(posedge mclk)
    srst |=> syncA_q == bsfr_status_t'(BSFR_STATUS_RESET)
      && syncB_q == bsfr_status_t'(BSFR_STATUS_RESET))
    else $error("condition pipe not cleared by reset");

  // ==========================================================
  // pin edge, then a read three edges later: the earliest edge
  // at which the status register already holds the new level
  sequence s_enableUp;
    $rose(condRaw.converterEnabled) ##3 s_statusRead;
  endsequence

  sequence s_enableDown;
    $fell(condRaw.converterEnabled) ##3 s_statusRead;
  endsequence

  sequence s_bootUp;
    $rose(condRaw.bootError) ##3 s_statusRead;
  endsequence

  sequence s_bootDown;
    $fell(condRaw.bootError) ##3 s_statusRead;
  endsequence

  sequence s_hiccupUp;
    $rose(condRaw.hiccupActive) ##3 s_statusRead;
  endsequence

  sequence s_hiccupDown;
    $fell(condRaw.hiccupActive) ##3 s_statusRead;
  endsequence

  sequence s_latchUp;
    $rose(condRaw.latchedOff) ##3 s_statusRead;
  endsequence

  sequence s_latchDown;
    $fell(condRaw.latchedOff) ##3 s_statusRead;
  endsequence

  sequence s_warnUp;
    $rose(condRaw.overtempWarningFlag) ##3 s_statusRead;
  endsequence

  sequence s_rampUp;
    $rose(condRaw.softstartRampComplete) ##3 s_statusRead;
  endsequence

  sequence s_faultUp;
    $rose(condRaw.overtempFaultFlag) ##3 s_statusRead;
  endsequence

  sequence s_goodUp;
    $rose(condRaw.outputInRegulation) ##3 s_statusRead;
  endsequence

  // ==========================================================
  // read data after such an edge
  a_enable_on: assert property (@(posedge mclk) disable iff (srst)
    s_enableUp |=> rdValid_q && rdData_q[BSFR_BIT_ENSTAT])
    else $error("enable bit not set after converter on");

  a_enable_off: assert property (@(posedge mclk) disable iff (srst)
    s_enableDown |=> rdValid_q && !rdData_q[BSFR_BIT_ENSTAT])
    else $error("enable bit still set after converter off");

  a_boot_set: assert property (@(posedge mclk) disable iff (srst)
    s_bootUp |=> rdValid_q && rdData_q[BSFR_BIT_BOOTERR])
    else $error("boot error bit not set");

  a_boot_clear: assert property (@(posedge mclk) disable iff (srst)
    s_bootDown |=> rdValid_q && !rdData_q[BSFR_BIT_BOOTERR])
    else $error("boot error bit not cleared");

  a_hiccup_enter: assert property (@(posedge mclk) disable iff (srst)
    s_hiccupUp |=> rdValid_q && rdData_q[BSFR_BIT_HICCUP])
    else $error("hiccup bit not set on entry");

  a_hiccup_leave: assert property (@(posedge mclk) disable iff (srst)
    s_hiccupDown |=> rdValid_q && !rdData_q[BSFR_BIT_HICCUP])
    else $error("hiccup bit not cleared on exit");

  a_latch_set: assert property (@(posedge mclk) disable iff (srst)
    s_latchUp |=> rdValid_q && rdData_q[BSFR_BIT_LATCHOFF])
    else $error("latch-off bit not set");

  a_latch_clear: assert property (@(posedge mclk) disable iff (srst)
    s_latchDown |=> rdValid_q && !rdData_q[BSFR_BIT_LATCHOFF])
    else $error("latch-off bit not cleared");

  a_warn_read: assert property (@(posedge mclk) disable iff (srst)
    s_warnUp |=> rdValid_q && rdData_q[BSFR_BIT_OTWARN])
    else $error("warning bit not set");

  a_ramp_read: assert property (@(posedge mclk) disable iff (srst)
    s_rampUp |=> rdValid_q && rdData_q[BSFR_BIT_SSDONE])
    else $error("ramp complete bit not set");

  a_fault_read: assert property (@(posedge mclk) disable iff (srst)
    s_faultUp |=> rdValid_q && rdData_q[BSFR_BIT_OTFAULT])
    else $error("overtemp fault bit not set");

  a_good_read: assert property (@(posedge mclk) disable iff (srst)
    s_goodUp |=> rdValid_q && rdData_q[BSFR_BIT_PGOOD])
    else $error("power good bit not set");

endmodule : bsfr_status_reg

// ===== test/bsfr_host_model.sv
`timescale 1ns/10ps
module bsfr_host_model
  import bsfr_pkg::*;
(
  // clock
  input wire logic mclk,
  // read port
  output logic rdEn,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData_q,
  input wire logic rdValid_q
);
  initial begin
    rdEn = 1'b0;
    rdAddr = 8'h00;
  end
  // released address is inverted so a stale value never passes
  task automatic doRead(input logic [7:0] a, output logic [8:0] r);
    @(posedge mclk);
    rdEn <= 1'b1;
    rdAddr <= a;
    @(posedge mclk);
    rdEn <= 1'b0;
    rdAddr <= ~a;
    // answer is registered on the taking edge itself; look mid-cycle
    @(negedge mclk);
    r = {rdValid_q, rdData_q};
  endtask : doRead
endmodule : bsfr_host_model

// ===== test/tb_bsfr_status_reg.sv
`timescale 1ns/10ps
module tb_bsfr_status_reg
  import bsfr_pkg::*;
;
  logic mclk, srst, rdEn, rdValid_q;
  logic [7:0] rdAddr, rdData_q;
  logic [8:0] r;
  bsfr_status_t condRaw;
  int num_errors = 0;
  int checked = 0;
  bsfr_status_reg bsfr_status_reg_i(.mclk(mclk), .srst(srst), .condRaw(condRaw),
    .rdEn(rdEn), .rdAddr(rdAddr), .rdData_q(rdData_q), .rdValid_q(rdValid_q));
  bsfr_host_model bsfr_host_model_i(.mclk(mclk), .rdEn(rdEn), .rdAddr(rdAddr),
    .rdData_q(rdData_q), .rdValid_q(rdValid_q));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic results();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // next read is taken on the earliest edge that may show the new level
  task automatic setCond(input logic [7:0] v);
    @(posedge mclk);
    condRaw <= bsfr_status_t'(v);
    repeat (2) @(posedge mclk);
  endtask : setCond
  task automatic oneField(input string n, input bsfr_status_t c, input int pos);
    setCond(c);
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk(n, r, {1'b1, 8'h01 << pos});
  endtask : oneField
  task automatic t_bits();
    for (int i = 0; i < 8; i++) begin
      setCond(8'h01 << i);
      bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
      chk("one bit", r, {1'b1, 8'h01 << i});
    end
    $display("test bits done");
  endtask : t_bits
  task automatic t_map();
    setCond(8'hff);
    bsfr_host_model_i.doRead(8'h04, r);
    chk("unmapped", r, 9'h100);
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk("all set", r, 9'h1ff);
    @(negedge mclk);
    chk("idle after read", {rdValid_q, rdData_q}, 9'h000);
    setCond(8'h00);
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk("not sticky", r, 9'h100);
    $display("test map done");
  endtask : t_map
  task automatic t_named();
    bsfr_status_t c;
    c = '0;
    c.converterEnabled = 1'b1;
    oneField("enable bit", c, BSFR_BIT_ENSTAT);
    c = '0;
    c.bootError = 1'b1;
    oneField("boot error bit", c, BSFR_BIT_BOOTERR);
    c = '0;
    c.hiccupActive = 1'b1;
    oneField("hiccup bit", c, BSFR_BIT_HICCUP);
    c = '0;
    c.latchedOff = 1'b1;
    oneField("latch-off bit", c, BSFR_BIT_LATCHOFF);
    c = '0;
    c.overtempWarningFlag = 1'b1;
    oneField("warning bit", c, BSFR_BIT_OTWARN);
    c = '0;
    c.softstartRampComplete = 1'b1;
    oneField("ramp bit", c, BSFR_BIT_SSDONE);
    c = '0;
    c.overtempFaultFlag = 1'b1;
    oneField("fault bit", c, BSFR_BIT_OTFAULT);
    c = '0;
    c.outputInRegulation = 1'b1;
    oneField("power good bit", c, BSFR_BIT_PGOOD);
    $display("test named done");
  endtask : t_named
  task automatic t_reset();
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk("reset", r, {1'b1, BSFR_STATUS_RESET});
    $display("test reset done");
  endtask : t_reset
  task automatic t_midrst();
    setCond(8'hff);
    @(posedge mclk);
    srst <= 1'b1;
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk("read in reset", r, 9'h000);
    @(posedge mclk);
    srst <= 1'b0;
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk("first after reset", r, {1'b1, BSFR_STATUS_RESET});
    bsfr_host_model_i.doRead(BSFR_ADDR_STATUS, r);
    chk("pipe refilled", r, 9'h1ff);
    setCond(8'h00);
    $display("test mid reset done");
  endtask : t_midrst
  initial begin
    repeat (2000) @(posedge mclk);
    num_errors++;
    results();
  end
  initial begin
    srst = 1'b1;
    condRaw = '0;
    t_reset();
    t_bits();
    t_named();
    t_map();
    t_midrst();
    results();
  end
endmodule : tb_bsfr_status_reg
